//--- rtl/ftc_params.svh
/*
  constants for the flash timing and configuration block: register
  indices, reset values, field positions and counter widths.
  assumes inclusion by the prescaler, the core and the testbench, after the package.

// Summary of operation
// R1: start delay register, reset 18h, waits count plus one prescaler ticks.
// R2: transition register, reset 30h, waits count plus one prescaler ticks.
// R3: program pulse lasts eight times count plus one ticks; reset 16h.
// R4: page erase pulse lasts 4096 times count plus one ticks; reset 04h.
// R5: module erase pulse lasts 4096 times count plus one ticks; reset EAh.
// R6: end delay after program or erase is count plus one ticks; reset 18h.
// R7: module end delay is eight times count plus one ticks; reset 3Ch.
// R8: recovery delay between accesses is count plus one ticks; reset 04h.
// R9: software never writes timing registers while the busy flag is set.
// R10: timing defaults load at reset only when the flash array is idle.
// R11: function word from information block 0 is captured at reset, read only.
// R12: function word bit 0 low forces the usb transceiver into low power.
// R13: protection word from information block 1 is captured at reset, read only.
// R14: every auto-read register has a second-bus mirror with identical value.
// R15: code start address: bits 12:9 inverted boot field, the rest zero.
// R16: code start address is presented to the processor as reset branch offset.
// R17: prescaler divides system clock by divider plus one, giving the tick.
// R18: busy flag stays set for the whole program or erase operation.
// R19: phases run start, transition, pulse, end or module end, recovery, idle.
// R20: each phase counter reloads at phase start, decrements once per tick.
*/
`ifndef FTC_PARAMS_SVH
`define FTC_PARAMS_SVH

// register indices on the cpu register port
`define FTC_IDX_START 5'h00
`define FTC_IDX_TRAN 5'h01
`define FTC_IDX_PROG 5'h02
`define FTC_IDX_PERASE 5'h03
`define FTC_IDX_MERASE 5'h04
`define FTC_IDX_END 5'h05
`define FTC_IDX_MEND 5'h06
`define FTC_IDX_RCV 5'h07
`define FTC_IDX_PRESCALE 5'h08
`define FTC_IDX_FUNC 5'h10
`define FTC_IDX_PROT 5'h11
`define FTC_IDX_CODE 5'h12

// reset values
`define FTC_RST_START 8'h18
`define FTC_RST_TRAN 8'h30
`define FTC_RST_PROG 8'h16
`define FTC_RST_PERASE 8'h04
`define FTC_RST_MERASE 8'hEA
`define FTC_RST_END 8'h18
`define FTC_RST_MEND 8'h3C
`define FTC_RST_RCV 8'h04
`define FTC_RST_PRESCALE 5'h04

// widths and field positions
`define FTC_NUM_TIMING 8
`define FTC_CNT_W 20
`define FTC_DIV_W 5
`define FTC_USB_EN_BIT 0
`define FTC_BOOT_LSB 0
`define FTC_BOOT_W 4
`define FTC_CODE_ADDR_LSB 9

`endif

//--- rtl/ftc_pkg.sv
/*
  types of the flash timing and configuration block.
  assumes nothing of its surroundings.
*/
package ftc_pkg;

  typedef enum logic [1:0] {
    FTC_OP_PROGRAM,
    FTC_OP_PAGE_ERASE,
    FTC_OP_MODULE_ERASE,
    FTC_OP_NONE
  } ftc_op_t;

  typedef enum logic [2:0] {
    FTC_ST_IDLE,
    FTC_ST_START,
    FTC_ST_TRAN,
    FTC_ST_PULSE,
    FTC_ST_END,
    FTC_ST_MEND,
    FTC_ST_RCV
  } ftc_state_t;

endpackage

//--- rtl/ftc_prescaler.sv
/*
  flash prescaler: divides the system clock into a one-cycle tick.
  assumes a divider value held stable while the flash is busy.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ftc_params.svh"

module ftc_prescaler (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // divider setting
  input wire logic [`FTC_DIV_W-1:0] i_divider,
  // tick out
  output logic o_tick
);

  logic [`FTC_DIV_W-1:0] div_cnt_reg;
  logic [`FTC_DIV_W-1:0] div_cnt_next;

  // R17: divide by divider plus one
  always_comb begin
    if (div_cnt_reg == '0) begin
      div_cnt_next = i_divider;
    end else begin
      div_cnt_next = div_cnt_reg - `FTC_DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  assign o_tick = (div_cnt_reg == '0) && !i_srst;

  tick_spacing_a: assert property (  // R17
    @(posedge i_clk) disable iff (i_srst)
    (o_tick && i_divider == `FTC_DIV_W'(1) && $stable(i_divider)) |=> !o_tick ##1 o_tick)
    else $error("prescaler tick spacing wrong");

endmodule
`default_nettype wire

//--- rtl/ftc_core.sv
/*
  flash timing and configuration core: timing reload registers, auto-read
  copies of information block words, and the program/erase phase sequencer.
  assumes a single-cycle cpu register port, a second-bus read port for the
  mirrors, and information block words valid while reset is held.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ftc_params.svh"

module ftc_core (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // flash array state at reset
  input wire logic i_array_idle,
  // information block words
  input wire logic [15:0] i_info_function_word,
  input wire logic [15:0] i_info_protection_word,
  // cpu register port
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [4:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // second-bus mirror read port
  input wire logic i_mir_rd,
  input wire logic [4:0] i_mir_addr,
  output logic [15:0] o_mir_rdata,
  // operation request
  input wire logic i_op_start,
  input wire ftc_pkg::ftc_op_t i_op_kind,
  // sequencer status
  output logic o_flash_busy_flag,
  output logic o_pulse_active,
  output ftc_pkg::ftc_op_t o_pulse_kind,
  // usb transceiver power
  input wire logic i_usb_ctrl_lowpower,
  output logic o_usb_xcvr_lowpower,
  // reset branch displacement
  output logic [15:0] o_code_area_addr
);

  function automatic logic [7:0] timing_reset(input int idx);
    case (idx)
      0: timing_reset = `FTC_RST_START;
      1: timing_reset = `FTC_RST_TRAN;
      2: timing_reset = `FTC_RST_PROG;
      3: timing_reset = `FTC_RST_PERASE;
      4: timing_reset = `FTC_RST_MERASE;
      5: timing_reset = `FTC_RST_END;
      6: timing_reset = `FTC_RST_MEND;
      default: timing_reset = `FTC_RST_RCV;
    endcase
  endfunction

  // decode of the three auto-read registers, shared by both read ports
  function automatic logic [15:0] auto_read(input logic [4:0] addr, input logic [15:0] func,
                                            input logic [15:0] prot, input logic [15:0] code);
    case (addr)
      `FTC_IDX_FUNC: auto_read = func;
      `FTC_IDX_PROT: auto_read = prot;
      `FTC_IDX_CODE: auto_read = code;
      default: auto_read = 16'h0000;
    endcase
  endfunction

  logic [7:0] timing_reg [0:`FTC_NUM_TIMING-1];
  logic [7:0] timing_next [0:`FTC_NUM_TIMING-1];
  logic [`FTC_DIV_W-1:0] prescale_reg;
  logic [`FTC_DIV_W-1:0] prescale_next;
  logic [15:0] func_word_reg;
  logic [15:0] prot_word_reg;
  logic [15:0] code_addr_reg;
  logic [15:0] func_word_next;
  logic [15:0] prot_word_next;
  logic [15:0] code_addr_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [15:0] mir_rdata_reg;
  logic [15:0] mir_rdata_next;
  ftc_pkg::ftc_state_t state_reg;
  ftc_pkg::ftc_state_t state_next;
  ftc_pkg::ftc_op_t kind_reg;
  ftc_pkg::ftc_op_t kind_next;
  logic [`FTC_CNT_W-1:0] cnt_reg;
  logic [`FTC_CNT_W-1:0] cnt_next;
  logic tick;
  logic expire;

  ftc_prescaler u_prescaler (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_divider(prescale_reg),
    .o_tick(tick)
  );

  // timing reload registers; busy writes not blocked, software keeps off them, saving the interlock
  genvar gi;
  generate
    for (gi = 0; gi < `FTC_NUM_TIMING; gi++) begin : g_timing
      always_comb begin
        timing_next[gi] = timing_reg[gi];
        // R10: defaults only if array idle
        if (i_srst) begin
          if (i_array_idle) begin
            timing_next[gi] = timing_reset(gi);
          end
        // R9: software avoids busy writes
        end else if (i_reg_wr && i_reg_addr == 5'(gi)) begin
          timing_next[gi] = i_reg_wdata;
        end
      end
      always_ff @(posedge i_clk) begin
        timing_reg[gi] <= timing_next[gi];
      end
    end
  endgenerate

  always_comb begin
    prescale_next = prescale_reg;
    if (i_srst) begin
      if (i_array_idle) begin
        prescale_next = `FTC_RST_PRESCALE;
      end
    end else if (i_reg_wr && i_reg_addr == `FTC_IDX_PRESCALE) begin
      prescale_next = i_reg_wdata[`FTC_DIV_W-1:0];
    end
  end
  always_ff @(posedge i_clk) begin
    prescale_reg <= prescale_next;
  end

  // auto-read copies, captured on every cycle of reset, frozen after it
  always_comb begin
    func_word_next = func_word_reg;
    prot_word_next = prot_word_reg;
    code_addr_next = code_addr_reg;
    if (i_srst) begin
      // R11: function word capture
      func_word_next = i_info_function_word;
      // R13: protection word capture
      prot_word_next = i_info_protection_word;
      // R15: inverted boot field
      code_addr_next = 16'h0000;
      code_addr_next[`FTC_CODE_ADDR_LSB +: `FTC_BOOT_W] = ~i_info_protection_word[`FTC_BOOT_LSB +: `FTC_BOOT_W];
    end
  end
  always_ff @(posedge i_clk) begin
    func_word_reg <= func_word_next;
    prot_word_reg <= prot_word_next;
    code_addr_reg <= code_addr_next;
  end

  // read ports; unmapped indices read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (i_srst) begin
      rdata_next = 16'h0000;
    end else if (i_reg_rd) begin
      if (i_reg_addr < 5'(`FTC_NUM_TIMING)) begin
        rdata_next = {8'h00, timing_reg[i_reg_addr[2:0]]};
      end else if (i_reg_addr == `FTC_IDX_PRESCALE) begin
        rdata_next = {11'h000, prescale_reg};
      end else begin
        rdata_next = auto_read(i_reg_addr, func_word_reg, prot_word_reg, code_addr_reg);
      end
    end
  end

  // R14: mirror returns same value
  always_comb begin
    mir_rdata_next = mir_rdata_reg;
    if (i_srst) begin
      mir_rdata_next = 16'h0000;
    end else if (i_mir_rd) begin
      mir_rdata_next = auto_read(i_mir_addr, func_word_reg, prot_word_reg, code_addr_reg);
    end
  end

  always_ff @(posedge i_clk) begin
    rdata_reg <= rdata_next;
    mir_rdata_reg <= mir_rdata_next;
  end

  assign expire = tick && (cnt_reg == '0);

  // phase sequencer
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ftc_pkg::FTC_ST_IDLE: begin
        if (i_op_start && i_op_kind != ftc_pkg::FTC_OP_NONE) begin
          // R1: start delay load
          state_next = ftc_pkg::FTC_ST_START;
          kind_next = i_op_kind;
          cnt_next = `FTC_CNT_W'(timing_reg[0]);
        end
      end
      ftc_pkg::FTC_ST_START: begin
        if (expire) begin
          // R2: transition delay load
          state_next = ftc_pkg::FTC_ST_TRAN;
          cnt_next = `FTC_CNT_W'(timing_reg[1]);
        end
      end
      ftc_pkg::FTC_ST_TRAN: begin
        if (expire) begin
          state_next = ftc_pkg::FTC_ST_PULSE;
          case (kind_reg)
            // R3: eight ticks per step
            ftc_pkg::FTC_OP_PROGRAM: cnt_next = `FTC_CNT_W'({timing_reg[2], 3'h7});
            // R4: page erase 4096 per step
            ftc_pkg::FTC_OP_PAGE_ERASE: cnt_next = {timing_reg[3], 12'hFFF};
            // R5: module erase 4096 per step
            default: cnt_next = {timing_reg[4], 12'hFFF};
          endcase
        end
      end
      ftc_pkg::FTC_ST_PULSE: begin
        if (expire) begin
          if (kind_reg == ftc_pkg::FTC_OP_MODULE_ERASE) begin
            // R7: module end delay load
            state_next = ftc_pkg::FTC_ST_MEND;
            cnt_next = `FTC_CNT_W'({timing_reg[6], 3'h7});
          end else begin
            // R6: end delay load
            state_next = ftc_pkg::FTC_ST_END;
            cnt_next = `FTC_CNT_W'(timing_reg[5]);
          end
        end
      end
      ftc_pkg::FTC_ST_END, ftc_pkg::FTC_ST_MEND: begin
        if (expire) begin
          // R8: recovery delay load
          state_next = ftc_pkg::FTC_ST_RCV;
          cnt_next = `FTC_CNT_W'(timing_reg[7]);
        end
      end
      ftc_pkg::FTC_ST_RCV: begin
        if (expire) begin
          // R19: back to idle
          state_next = ftc_pkg::FTC_ST_IDLE;
          kind_next = ftc_pkg::FTC_OP_NONE;
        end
      end
      default: begin
        state_next = ftc_pkg::FTC_ST_IDLE;
      end
    endcase
    // R20: one decrement per tick
    if (state_reg != ftc_pkg::FTC_ST_IDLE && tick && cnt_reg != '0) begin
      cnt_next = cnt_reg - `FTC_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= ftc_pkg::FTC_ST_IDLE;
      kind_reg <= ftc_pkg::FTC_OP_NONE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      cnt_reg <= cnt_next;
    end
  end

  // R18: busy across all phases
  assign o_flash_busy_flag = (state_reg != ftc_pkg::FTC_ST_IDLE);
  assign o_pulse_active = (state_reg == ftc_pkg::FTC_ST_PULSE);
  assign o_pulse_kind = kind_reg;
  assign o_reg_rdata = rdata_reg;
  assign o_mir_rdata = mir_rdata_reg;
  // R12: usb enable bit gates power
  assign o_usb_xcvr_lowpower = !func_word_reg[`FTC_USB_EN_BIT] || i_usb_ctrl_lowpower;
  // R16: reset branch offset
  assign o_code_area_addr = code_addr_reg;

  start_accept_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R18
    (!o_flash_busy_flag && i_op_start && i_op_kind != ftc_pkg::FTC_OP_NONE) |=> o_flash_busy_flag)
    else $error("busy not raised on start");
  start_load_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R1
    (state_reg == ftc_pkg::FTC_ST_IDLE && i_op_start && i_op_kind != ftc_pkg::FTC_OP_NONE)
    |=> (state_reg == ftc_pkg::FTC_ST_START && cnt_reg == `FTC_CNT_W'($past(timing_reg[0]))))
    else $error("start delay not loaded");
  tran_load_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R2
    (state_reg == ftc_pkg::FTC_ST_START && expire)
    |=> (state_reg == ftc_pkg::FTC_ST_TRAN && cnt_reg == `FTC_CNT_W'(timing_reg[1])))
    else $error("transition delay not loaded");
  prog_pulse_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R3
    (state_reg == ftc_pkg::FTC_ST_TRAN && expire && kind_reg == ftc_pkg::FTC_OP_PROGRAM)
    |=> (o_pulse_active && cnt_reg == `FTC_CNT_W'({timing_reg[2], 3'h7})))
    else $error("program pulse length wrong");
  page_pulse_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R4
    (state_reg == ftc_pkg::FTC_ST_TRAN && expire && kind_reg == ftc_pkg::FTC_OP_PAGE_ERASE)
    |=> (o_pulse_active && cnt_reg == {timing_reg[3], 12'hFFF}))
    else $error("page erase pulse length wrong");
  module_pulse_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R5
    (state_reg == ftc_pkg::FTC_ST_TRAN && expire && kind_reg == ftc_pkg::FTC_OP_MODULE_ERASE)
    |=> (o_pulse_active && cnt_reg == {timing_reg[4], 12'hFFF}))
    else $error("module erase pulse length wrong");
  end_delay_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R6
    (o_pulse_active && expire && kind_reg != ftc_pkg::FTC_OP_MODULE_ERASE)
    |=> (state_reg == ftc_pkg::FTC_ST_END && cnt_reg == `FTC_CNT_W'(timing_reg[5])))
    else $error("end delay not entered");
  mend_delay_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R7
    (o_pulse_active && expire && kind_reg == ftc_pkg::FTC_OP_MODULE_ERASE)
    |=> (state_reg == ftc_pkg::FTC_ST_MEND && cnt_reg == `FTC_CNT_W'({timing_reg[6], 3'h7})))
    else $error("module end delay not entered");
  recovery_end_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R8
    (state_reg == ftc_pkg::FTC_ST_RCV && expire) |=> (!o_flash_busy_flag ##1 1'b1))
    else $error("recovery did not end in idle");
  count_step_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R20
    (o_flash_busy_flag && tick && cnt_reg != '0)
    |=> (cnt_reg == $past(cnt_reg) - `FTC_CNT_W'(1)))
    else $error("phase counter did not step");
  reset_keep_a: assert property (@(posedge i_clk)  // R10
    (i_srst && !i_array_idle) |=> (timing_reg[0] == $past(timing_reg[0])))
    else $error("timing register reloaded while array busy");
  usb_force_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R12
    !func_word_reg[`FTC_USB_EN_BIT] |-> o_usb_xcvr_lowpower)
    else $error("usb transceiver not forced low power");
  mirror_same_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R14
    (i_mir_rd && i_mir_addr == `FTC_IDX_FUNC) |=> (o_mir_rdata == func_word_reg))
    else $error("mirror differs from primary");
  code_fixed_a: assert property (@(posedge i_clk) disable iff (i_srst)  // R15
    (o_code_area_addr[8:0] == 9'h000 && o_code_area_addr[15:13] == 3'h0))
    else $error("code address fixed bits not zero");

endmodule
`default_nettype wire

//--- rtl/ftc_top_note_unused.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- sim/ftc_array_model.sv
/*
  flash array model: information block words, idle state and a pulse meter.
  assumes the timing core's busy and pulse outputs on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module ftc_array_model #(
  parameter logic [15:0] FUNC_A = 16'h0001,
  parameter logic [15:0] FUNC_B = 16'h0000,
  parameter logic [15:0] PROT_A = 16'hA5C3,
  parameter logic [15:0] PROT_B = 16'h5A3C
) (
  // clock
  input wire logic i_clk,
  // core status
  input wire logic i_busy,
  input wire logic i_pulse,
  // bench controls
  input wire logic i_force_busy,
  input wire logic i_alt,
  // array side
  output logic o_array_idle,
  output logic [15:0] o_func,
  output logic [15:0] o_prot,
  output int o_pulse_len
);
  int cnt = 0;

  assign o_array_idle = !i_busy && !i_force_busy;
  assign o_func = i_alt ? FUNC_B : FUNC_A;
  assign o_prot = i_alt ? PROT_B : PROT_A;

  // pulse length in clocks, latched when it ends
  initial o_pulse_len = 0;
  always @(posedge i_clk) begin
    if (i_pulse) begin
      cnt <= cnt + 1;
    end else if (cnt != 0) begin
      o_pulse_len <= cnt;
      cnt <= 0;
    end
  end
endmodule

`default_nettype wire

//--- sim/test_flash_timing_config.sv
/*
  testbench of the flash timing core beside the flash array model.
  assumes a 25 MHz clock and a synchronous reset held 12 cycles at start, 3 cycles in do_reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ftc_params.svh"

module test_flash_timing_config;
  localparam logic [15:0] FUNC_A = 16'h0001;
  localparam logic [15:0] FUNC_B = 16'h0000;
  localparam logic [15:0] PROT_A = 16'hA5C3;
  localparam logic [15:0] PROT_B = 16'h5A3C;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_mir_rd = 1'b0;
  logic [4:0] i_reg_addr = 5'h00;
  logic [4:0] i_mir_addr = 5'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_op_start = 1'b0;
  ftc_pkg::ftc_op_t i_op_kind = ftc_pkg::FTC_OP_NONE;
  logic i_usb_ctrl_lowpower = 1'b0;
  logic force_busy = 1'b0;
  logic alt_words = 1'b0;
  logic array_idle, busy, pulse, usb_lp;
  logic [15:0] func_w, prot_w, reg_rdata, mir_rdata, code_addr;
  ftc_pkg::ftc_op_t pulse_kind;
  int pulse_len;
  int num_errors = 0;
  int checks = 0;

  ftc_core i_ftc_core (.i_clk(i_clk), .i_srst(i_srst), .i_array_idle(array_idle),
    .i_info_function_word(func_w), .i_info_protection_word(prot_w), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(reg_rdata), .i_mir_rd(i_mir_rd), .i_mir_addr(i_mir_addr),
    .o_mir_rdata(mir_rdata), .i_op_start(i_op_start), .i_op_kind(i_op_kind),
    .o_flash_busy_flag(busy), .o_pulse_active(pulse), .o_pulse_kind(pulse_kind),
    .i_usb_ctrl_lowpower(i_usb_ctrl_lowpower), .o_usb_xcvr_lowpower(usb_lp),
    .o_code_area_addr(code_addr));

  ftc_array_model #(.FUNC_A(FUNC_A), .FUNC_B(FUNC_B), .PROT_A(PROT_A), .PROT_B(PROT_B))
    i_ftc_array_model (.i_clk(i_clk), .i_busy(busy), .i_pulse(pulse),
    .i_force_busy(force_busy), .i_alt(alt_words), .o_array_idle(array_idle),
    .o_func(func_w), .o_prot(prot_w), .o_pulse_len(pulse_len));

  initial begin
    forever #20 i_clk = ~i_clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("[FAIL] %0t count %0d expected %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(posedge i_clk);
    #1;
    i_reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [4:0] a, input logic mir, output logic [15:0] d);
    @(posedge i_clk);
    #1;
    i_reg_rd = !mir;
    i_mir_rd = mir;
    i_reg_addr = a;
    i_mir_addr = a;
    @(posedge i_clk);
    #1;
    i_reg_rd = 1'b0;
    i_mir_rd = 1'b0;
    d = mir ? mir_rdata : reg_rdata;
  endtask

  task automatic do_reset();
    i_srst = 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
  endtask

  // no register writes while busy; second start only when asked
  task automatic run_op(input ftc_pkg::ftc_op_t k, input logic extra, output int n);
    n = 0;
    @(posedge i_clk);
    #1;
    i_op_start = 1'b1;
    i_op_kind = k;
    @(posedge i_clk);
    #1;
    i_op_start = 1'b0;
    while (busy === 1'b1 && n < 60000) begin
      i_op_start = extra && n == 4;
      if (n == 1) begin
        check16({14'h0000, pulse_kind}, {14'h0000, k});
      end
      @(posedge i_clk);
      #1;
      n++;
    end
    i_op_start = 1'b0;
  endtask

  task automatic t_defaults();
    logic [7:0] exp [9];
    logic [15:0] d;
    exp = '{8'h18, 8'h30, 8'h16, 8'h04, 8'hEA, 8'h18, 8'h3C, 8'h04, 8'h04};
    for (int i = 0; i < 9; i++) begin
      reg_read(5'(i), 1'b0, d);
      check16(d, {8'h00, exp[i]});
    end
    reg_write(5'h09, 8'hFF);
    reg_read(5'h09, 1'b0, d);
    check16(d, 16'h0000);
    reg_read(`FTC_IDX_PRESCALE, 1'b0, d);
    check16(d, 16'h0004);
    check16({14'h0000, pulse_kind}, 16'h0003);
  endtask

  task automatic t_autoread(input logic [15:0] fw, input logic [15:0] pw);
    logic [15:0] d;
    logic [15:0] ca;
    ca = {3'b000, ~pw[3:0], 9'h000};
    reg_read(`FTC_IDX_FUNC, 1'b0, d);
    check16(d, fw);
    reg_read(`FTC_IDX_PROT, 1'b0, d);
    check16(d, pw);
    reg_read(`FTC_IDX_CODE, 1'b0, d);
    check16(d, ca);
    check16(code_addr, ca);
    for (int i = 0; i < 3; i++) begin
      reg_read(5'(16 + i), 1'b1, d);
      check16(d, i == 0 ? fw : (i == 1 ? pw : ca));
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge i_clk);
      #1;
      i_usb_ctrl_lowpower = i[0];
      #1;
      check_bit(usb_lp, !fw[0] || i[0]);
    end
    @(posedge i_clk);
    #1;
    i_usb_ctrl_lowpower = 1'b0;
  endtask

  task automatic t_program();
    int n;
    logic [15:0] d;
    reg_write(`FTC_IDX_START, 8'h01);
    reg_write(`FTC_IDX_TRAN, 8'h02);
    reg_write(`FTC_IDX_PROG, 8'h01);
    reg_write(`FTC_IDX_END, 8'h03);
    reg_write(`FTC_IDX_RCV, 8'h00);
    reg_write(`FTC_IDX_PRESCALE, 8'h00);
    reg_read(`FTC_IDX_TRAN, 1'b0, d);
    check16(d, 16'h0002);
    run_op(ftc_pkg::FTC_OP_PROGRAM, 1'b1, n);
    check_cnt(n, 2 + 3 + 16 + 4 + 1, 26);
    check_cnt(pulse_len, 16, 16);
    run_op(ftc_pkg::FTC_OP_NONE, 1'b0, n);
    check_cnt(n, 0, 0);
  endtask

  task automatic t_erase();
    int n;
    reg_write(`FTC_IDX_PERASE, 8'h00);
    reg_write(`FTC_IDX_MERASE, 8'h00);
    reg_write(`FTC_IDX_MEND, 8'h01);
    run_op(ftc_pkg::FTC_OP_PAGE_ERASE, 1'b0, n);
    check_cnt(n, 2 + 3 + 4096 + 4 + 1, 4106);
    check_cnt(pulse_len, 4096, 4096);
    run_op(ftc_pkg::FTC_OP_MODULE_ERASE, 1'b0, n);
    check_cnt(n, 2 + 3 + 4096 + 16 + 1, 4118);
    check_cnt(pulse_len, 4096, 4096);
  endtask

  task automatic t_prescale();
    int n;
    reg_write(`FTC_IDX_PRESCALE, 8'h01);
    run_op(ftc_pkg::FTC_OP_PROGRAM, 1'b0, n);
    check_cnt(n, 2 * 26 - 1, 2 * 26);
    check_cnt(pulse_len, 2 * 16, 32);
    reg_write(`FTC_IDX_PRESCALE, 8'h00);
  endtask

  task automatic t_reset_busy();
    logic [15:0] d;
    reg_write(`FTC_IDX_START, 8'h55);
    force_busy = 1'b1;
    alt_words = 1'b1;
    do_reset();
    force_busy = 1'b0;
    reg_read(`FTC_IDX_START, 1'b0, d);
    check16(d, 16'h0055);
    t_autoread(FUNC_B, PROT_B);
    alt_words = 1'b0;
    do_reset();
    reg_read(`FTC_IDX_START, 1'b0, d);
    check16(d, 16'h0018);
  endtask

  initial begin
    #(20000 * 40);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (12) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    t_defaults();
    t_autoread(FUNC_A, PROT_A);
    t_program();
    t_erase();
    t_prescale();
    t_reset_busy();
    finish_test();
  end
endmodule

`default_nettype wire
